// >>> sfx_bank.sv
// One FIFO bank: pin control, flags, offsets, depth chain, register slave
//
// Design decisions made here: the register addresses and the Avalon-MM interface to the registers.
`default_nettype none

// Summary of operation
// R1 - Drive data bus while output enable low
// R2 - Load low, write enable: capture offset bits
// R3 - Load low, read enable: show offset bits
// R4 - Chain head low marks first device
// R5 - Chain inputs grounded alone, chained otherwise
// R6 - Empty flag low when empty, blocks reads
// R7 - Full flag low when full, blocks writes
// R8 - Near-empty low within offset of empty
// R9 - Near-full low within offset of full
// R10 - Half flag low above half, single use
// R11 - Pulse write chain out on last write
// R12 - Pulse read chain out on last read
// R13 - Write enable low stores word unless full
// R14 - Read enable low advances output unless empty
// R15 - Pin reset clears pointers, sets flags
// R16 - Load accesses alternate offset registers, reset restarts
// R17 - Each instance is an independent bank
module sfx_bank import sfx_pkg::*; (
  // Clock and system reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Write side pins
  input wire logic wr_clk_i,
  input wire logic wr_en_n_i,
  input wire logic [DATA_W-1:0] data_i,
  // Read side pins
  input wire logic rd_clk_i,
  input wire logic rd_en_n_i,
  input wire logic out_en_n_i,
  output logic [DATA_W-1:0] data_o,
  output logic data_oe_o,
  // Control pins
  input wire logic rst_n_i,
  input wire logic offset_access_n_i,
  input wire logic chain_head_n_i,
  input wire logic wr_chain_in_n_i,
  input wire logic rd_chain_in_n_i,
  // Flags; write chain out shares its pin with the half flag
  output logic empty_n_o,
  output logic full_n_o,
  output logic near_empty_n_o,
  output logic near_full_n_o,
  output logic wr_chain_out_n_o,
  output logic rd_chain_out_n_o,
  // Avalon-MM slave
  input wire logic [AVS_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [AVS_DATA_W-1:0] avs_writedata_i,
  input wire logic [AVS_BE_W-1:0] avs_byteenable_i,
  output logic [AVS_DATA_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Interrupt
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State; nothing here is shared with another instance R17
  typedef struct packed {
    logic wclk_d;                    // Last write clock level
    logic rclk_d;                    // Last read clock level
    logic wci_d;                     // Last write chain in level
    logic rci_d;                     // Last read chain in level
    logic [CNT_W-1:0] wr_ptr;        // Write pointer with wrap bit
    logic [CNT_W-1:0] rd_ptr;        // Read pointer with wrap bit
    logic [OFS_W-1:0] ae_ofs;        // Near-empty offset
    logic [OFS_W-1:0] af_ofs;        // Near-full offset
    sfx_sel_e wr_sel;                // Next register for a load write
    sfx_sel_e rd_sel;                // Next register for a load read
    logic wr_tok;                    // This device owns writes in a chain
    logic rd_tok;                    // This device owns reads in a chain
    logic [CHAIN_W-1:0] wco_sh;      // Write chain pulse timer
    logic [CHAIN_W-1:0] rco_sh;      // Read chain pulse timer
    logic [DATA_W-1:0] q;            // Output register
    logic oe;                        // Output bus drive
    logic empty_n;
    logic full_n;
    logic ne_n;
    logic nf_n;
    logic half_n;
    logic xo_n;                      // Shared half / write chain pin
    logic rco_n;
    logic depth_mode;                // Software-selected chain mode
    logic [ST_W-1:0] status;         // Sticky events
    logic [ST_W-1:0] mask;           // Interrupt enables
    logic irq;
    logic wreq;                      // Avalon waitrequest
    logic [AVS_DATA_W-1:0] rdata;    // Avalon read data
  } sfx_bank_s;

  sfx_bank_s r_reg;
  sfx_bank_s r_next;

  // Synchronised pins and decoded strobes
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_s;
  logic pin_rst;                     // Pin reset held
  logic ofs_acc;                     // Load pin held
  logic wr_hit;                      // Rising write clock seen
  logic rd_hit;                      // Rising read clock seen
  logic wr_req;                      // Write edge with enable low
  logic rd_req;                      // Read edge with enable low
  logic wci_fall;
  logic rci_fall;
  logic mem_we;                      // Word accepted into memory
  logic rd_go;                       // Word taken from memory
  logic [DATA_W-1:0] mem_rdata;
  logic [CNT_W-1:0] cur_cnt;         // Words stored now
  logic [CNT_W-1:0] nxt_cnt;         // Words stored after this edge
  logic [ST_W-1:0] ev;               // Events of this cycle
  logic [ST_W-1:0] st_clr;           // Bits cleared by a status read

  ////////////////////////////////////////////////////////////////////////////
  // Pin capture: pin clocks must run well below the core clock
  assign pin_raw = {rst_n_i, wr_clk_i, rd_clk_i, wr_en_n_i, rd_en_n_i,
                    offset_access_n_i, chain_head_n_i, wr_chain_in_n_i,
                    rd_chain_in_n_i, out_en_n_i, data_i};

  sfx_sync #(
    .W(PIN_W),
    .RESET_VAL(PIN_IDLE)
  ) u_sync (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .async_i(pin_raw),
    .sync_o(pin_s)
  );

  // Word store
  sfx_mem u_mem (
    .core_clk_i(core_clk_i),
    .wr_en_i(mem_we),
    .wr_addr_i(r_reg.wr_ptr[PTR_W-1:0]),
    .wr_data_i(pin_s[P_DATA +: DATA_W]),
    .rd_addr_i(r_reg.rd_ptr[PTR_W-1:0]),
    .rd_data_o(mem_rdata)
  );

  assign cur_cnt = r_reg.wr_ptr - r_reg.rd_ptr;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic of the whole bank
  always_comb begin
    r_next = r_reg;
    ev = '0;
    st_clr = '0;
    // Edge detection on filtered levels
    pin_rst = !pin_s[P_RST];
    ofs_acc = !pin_s[P_OFS];
    wr_hit = pin_s[P_WCLK] && !r_reg.wclk_d;
    rd_hit = pin_s[P_RCLK] && !r_reg.rclk_d;
    wci_fall = !pin_s[P_WCI] && r_reg.wci_d;
    rci_fall = !pin_s[P_RCI] && r_reg.rci_d;
    r_next.wclk_d = pin_s[P_WCLK];
    r_next.rclk_d = pin_s[P_RCLK];
    r_next.wci_d = pin_s[P_WCI];
    r_next.rci_d = pin_s[P_RCI];
    wr_req = wr_hit && !pin_s[P_WEN];
    rd_req = rd_hit && !pin_s[P_REN];
    // Memory access; in a chain only the token holder moves data
    mem_we = wr_req && !ofs_acc && r_reg.full_n && !pin_rst &&
             (!r_reg.depth_mode || r_reg.wr_tok); // R13 R7
    rd_go = rd_req && !ofs_acc && r_reg.empty_n && !pin_rst &&
            (!r_reg.depth_mode || r_reg.rd_tok); // R14 R6
    // Output drive follows its enable pin
    r_next.oe = !pin_s[P_OE]; // R1

    // Chain pulse timers count down
    r_next.wco_sh = {1'b0, r_reg.wco_sh[CHAIN_W-1:1]};
    r_next.rco_sh = {1'b0, r_reg.rco_sh[CHAIN_W-1:1]};

    // Word write
    if (mem_we) begin
      r_next.wr_ptr = r_reg.wr_ptr + CNT_ONE;
      if (r_reg.depth_mode && r_reg.wr_ptr[PTR_W-1:0] == PTR_LAST) begin
        r_next.wco_sh = CHAIN_FILL; // R11
        r_next.wr_tok = 1'b0;
      end
    end
    // Word read into the output register; it holds unless a word or an offset is read
    if (rd_go) begin
      r_next.q = mem_rdata; // R14
      r_next.rd_ptr = r_reg.rd_ptr + CNT_ONE;
      if (r_reg.depth_mode && r_reg.rd_ptr[PTR_W-1:0] == PTR_LAST) begin
        r_next.rco_sh = CHAIN_FILL; // R12
        r_next.rd_tok = 1'b0;
      end
    end
    // Tokens handed on by the previous device; ignored when grounded
    if (r_reg.depth_mode && wci_fall) begin
      r_next.wr_tok = 1'b1; // R5
    end
    if (r_reg.depth_mode && rci_fall) begin
      r_next.rd_tok = 1'b1; // R5
    end

    // Offset load write, alternating registers
    if (wr_req && ofs_acc && !pin_rst) begin
      if (r_reg.wr_sel == SEL_EMPTY) begin
        r_next.ae_ofs = pin_s[P_DATA +: OFS_W]; // R2
        r_next.wr_sel = SEL_FULL; // R16
      end else begin
        r_next.af_ofs = pin_s[P_DATA +: OFS_W]; // R2
        r_next.wr_sel = SEL_EMPTY; // R16
      end
    end
    // Offset readback on the low output bits, upper bits zero
    if (rd_req && ofs_acc && !pin_rst) begin
      r_next.q = '0;
      if (r_reg.rd_sel == SEL_EMPTY) begin
        r_next.q[OFS_W-1:0] = r_reg.ae_ofs; // R3
        r_next.rd_sel = SEL_FULL; // R16
      end else begin
        r_next.q[OFS_W-1:0] = r_reg.af_ofs; // R3
        r_next.rd_sel = SEL_EMPTY; // R16
      end
    end

    // Pin reset overrides the pointers, offsets, selects, tokens and chain timers set above
    if (pin_rst) begin
      r_next.wr_ptr = CNT_ZERO; // R15
      r_next.rd_ptr = CNT_ZERO; // R15
      r_next.ae_ofs = OFS_DEFAULT; // R8
      r_next.af_ofs = OFS_DEFAULT; // R9
      r_next.wr_sel = SEL_EMPTY; // R16
      r_next.rd_sel = SEL_EMPTY; // R16
      r_next.wr_tok = !pin_s[P_HEAD]; // R4
      r_next.rd_tok = !pin_s[P_HEAD]; // R4
      r_next.wco_sh = CHAIN_IDLE;
      r_next.rco_sh = CHAIN_IDLE;
    end

    // Flags from the pointers after this edge
    nxt_cnt = r_next.wr_ptr - r_next.rd_ptr;
    r_next.empty_n = nxt_cnt != CNT_ZERO; // R6
    r_next.full_n = nxt_cnt != CNT_FULL; // R7
    r_next.ne_n = nxt_cnt > {1'b0, r_next.ae_ofs}; // R8
    r_next.nf_n = nxt_cnt < (CNT_FULL - {1'b0, r_next.af_ofs}); // R9
    r_next.half_n = !(nxt_cnt > CNT_HALF); // R10
    r_next.xo_n = r_reg.depth_mode ? !(|r_next.wco_sh) : r_next.half_n;
    r_next.rco_n = !(|r_next.rco_sh);

    // Events: flag assertions and refused accesses
    ev[ST_EMPTY] = r_reg.empty_n && !r_next.empty_n;
    ev[ST_FULL] = r_reg.full_n && !r_next.full_n;
    ev[ST_NEAR_E] = r_reg.ne_n && !r_next.ne_n;
    ev[ST_NEAR_F] = r_reg.nf_n && !r_next.nf_n;
    ev[ST_HALF] = r_reg.half_n && !r_next.half_n;
    ev[ST_OVER] = wr_req && !ofs_acc && !r_reg.full_n && !pin_rst;
    ev[ST_UNDER] = rd_req && !ofs_acc && !r_reg.empty_n && !pin_rst;

    // Avalon: first cycle of a request snapshots data, second completes
    r_next.wreq = 1'b1;
    if ((avs_read_i || avs_write_i) && r_reg.wreq) begin
      r_next.wreq = 1'b0;
      r_next.rdata = '0;
      case (avs_address_i)
        REG_CTRL: begin
          r_next.rdata[CTRL_DEPTH_BIT] = r_reg.depth_mode;
        end
        REG_STATUS: begin
          r_next.rdata[ST_W-1:0] = r_reg.status;
          // Cleared at the snapshot so no later event is lost
          if (avs_read_i) begin
            st_clr = r_reg.status;
          end
        end
        REG_MASK: begin
          r_next.rdata[ST_W-1:0] = r_reg.mask;
        end
        REG_LEVEL: begin
          r_next.rdata[CNT_W-1:0] = cur_cnt;
          r_next.rdata[LVL_FLAG_LSB +: LVL_FLAG_W] = {r_reg.half_n,
            r_reg.nf_n, r_reg.ne_n, r_reg.full_n, r_reg.empty_n};
        end
        default: begin
          r_next.rdata = '0;
        end
      endcase
    end
    // Write lands on the edge where the master sees waitrequest low
    if (avs_write_i && !r_reg.wreq && avs_byteenable_i[0]) begin
      case (avs_address_i)
        REG_CTRL: begin
          r_next.depth_mode = avs_writedata_i[CTRL_DEPTH_BIT];
        end
        REG_MASK: begin
          r_next.mask = avs_writedata_i[ST_W-1:0];
        end
        default: begin
          r_next.mask = r_reg.mask;
        end
      endcase
    end

    // Sticky status: a new event beats a simultaneous clear
    r_next.status = (r_reg.status & ~st_clr) | ev;
    r_next.irq = |(r_next.status & r_next.mask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; pin reset is still needed before the first write in depth mode
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      r_reg <= '0;
      r_reg.ae_ofs <= OFS_DEFAULT;
      r_reg.af_ofs <= OFS_DEFAULT;
      r_reg.full_n <= 1'b1;
      r_reg.nf_n <= 1'b1;
      r_reg.half_n <= 1'b1;
      r_reg.xo_n <= 1'b1;
      r_reg.rco_n <= 1'b1;
      r_reg.wreq <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from the state register
  assign data_o = r_reg.q;
  assign data_oe_o = r_reg.oe;
  assign empty_n_o = r_reg.empty_n;
  assign full_n_o = r_reg.full_n;
  assign near_empty_n_o = r_reg.ne_n;
  assign near_full_n_o = r_reg.nf_n;
  assign wr_chain_out_n_o = r_reg.xo_n;
  assign rd_chain_out_n_o = r_reg.rco_n;
  assign avs_readdata_o = r_reg.rdata;
  assign avs_waitrequest_o = r_reg.wreq;
  assign irq_o = r_reg.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  oe_follow_a: assert property ( // R1
    $fell(pin_s[P_OE]) |=> data_oe_o ##1 data_oe_o || $rose(pin_s[P_OE]))
    else $error("output drive did not follow enable");
  ofs_load_a: assert property ( // R2
    wr_req && ofs_acc && !pin_rst && r_reg.wr_sel == SEL_EMPTY |=>
    r_reg.ae_ofs == $past(pin_s[OFS_W-1:0]) && r_reg.wr_sel == SEL_FULL)
    else $error("offset load write wrong");
  ofs_read_a: assert property ( // R3
    rd_req && ofs_acc && !pin_rst && r_reg.rd_sel == SEL_FULL |=>
    data_o[OFS_W-1:0] == $past(r_reg.af_ofs) &&
    data_o[DATA_W-1:OFS_W] == '0)
    else $error("offset readback wrong");
  head_tok_a: assert property ( // R4
    pin_rst |=> r_reg.wr_tok == !$past(pin_s[P_HEAD]))
    else $error("chain head token wrong");
  empty_block_a: assert property (rd_req && !ofs_acc && !pin_rst && // R6
    !r_reg.empty_n |=> $stable(r_reg.rd_ptr) && $stable(data_o))
    else $error("read taken while empty");
  full_block_a: assert property (wr_req && !ofs_acc && !pin_rst && // R7
    !r_reg.full_n |=> $stable(r_reg.wr_ptr))
    else $error("write taken while full");
  flag_level_a: assert property ( // R6
    empty_n_o == (cur_cnt != CNT_ZERO) && full_n_o == (cur_cnt != CNT_FULL))
    else $error("empty or full flag disagrees with count");
  near_empty_a: assert property ( // R8
    near_empty_n_o == (cur_cnt > {1'b0, r_reg.ae_ofs}))
    else $error("near-empty flag wrong");
  near_full_a: assert property ( // R9
    near_full_n_o == (cur_cnt < (CNT_FULL - {1'b0, r_reg.af_ofs})))
    else $error("near-full flag wrong");
  half_flag_a: assert property ( // R10
    !r_reg.depth_mode && !$past(r_reg.depth_mode) |->
    wr_chain_out_n_o == (cur_cnt <= CNT_HALF))
    else $error("half flag wrong");
  wr_chain_a: assert property ( // R11
    mem_we && r_reg.depth_mode && r_reg.wr_ptr[PTR_W-1:0] == PTR_LAST |=>
    !wr_chain_out_n_o [*2] ##1 wr_chain_out_n_o)
    else $error("write chain pulse wrong");
  rd_chain_a: assert property ( // R12
    rd_go && r_reg.depth_mode && r_reg.rd_ptr[PTR_W-1:0] == PTR_LAST |=>
    !rd_chain_out_n_o [*2] ##1 rd_chain_out_n_o)
    else $error("read chain pulse wrong");
  pin_reset_a: assert property ( // R15
    pin_rst |=> !empty_n_o && full_n_o && !near_empty_n_o && near_full_n_o
    && r_reg.wr_ptr == CNT_ZERO && r_reg.rd_ptr == CNT_ZERO)
    else $error("pin reset state wrong");

endmodule
`default_nettype wire

// >>> sfx_pkg.sv
// Shared constants and types for one bank of the flagged FIFO block
`default_nettype none
package sfx_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Data path geometry
  localparam int DATA_W = 18;            // Word width of each bank
  localparam int DEPTH = 1024;           // Words per bank
  localparam int PTR_W = 10;             // Memory address width
  localparam int CNT_W = 11;             // Pointer width with wrap bit
  localparam int OFS_W = 10;             // Offset register width
  localparam logic [OFS_W-1:0] OFS_DEFAULT = 10'h07F;  // Offset at reset
  localparam logic [CNT_W-1:0] CNT_ZERO = 11'h000;
  localparam logic [CNT_W-1:0] CNT_ONE = 11'h001;
  localparam logic [CNT_W-1:0] CNT_HALF = 11'h200;    // Half capacity
  localparam logic [CNT_W-1:0] CNT_FULL = 11'h400;    // Whole capacity
  localparam logic [PTR_W-1:0] PTR_LAST = 10'h3FF;    // Last location

  ////////////////////////////////////////////////////////////////////////////
  // Chain pulse: two core cycles so a peer's agreement filter sees it
  localparam int CHAIN_W = 2;
  localparam logic [CHAIN_W-1:0] CHAIN_FILL = 2'h3;
  localparam logic [CHAIN_W-1:0] CHAIN_IDLE = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Bit positions in the synchronised pin vector
  localparam int PIN_W = 28;
  localparam int P_DATA = 0;             // Data in, DATA_W bits
  localparam int P_OE = 18;              // Output enable, low active
  localparam int P_RCI = 19;             // Read chain in, low active
  localparam int P_WCI = 20;             // Write chain in, low active
  localparam int P_HEAD = 21;            // Chain head, low active
  localparam int P_OFS = 22;             // Offset access, low active
  localparam int P_REN = 23;             // Read enable, low active
  localparam int P_WEN = 24;             // Write enable, low active
  localparam int P_RCLK = 25;            // Read clock pin
  localparam int P_WCLK = 26;            // Write clock pin
  localparam int P_RST = 27;             // Pin reset, low active
  localparam logic [PIN_W-1:0] PIN_IDLE = 28'h9C40000;  // Quiet pin levels

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM register map, byte addresses
  localparam int AVS_ADDR_W = 4;
  localparam int AVS_DATA_W = 32;
  localparam int AVS_BE_W = 4;
  localparam logic [AVS_ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [AVS_ADDR_W-1:0] REG_STATUS = 4'h4;
  localparam logic [AVS_ADDR_W-1:0] REG_MASK = 4'h8;
  localparam logic [AVS_ADDR_W-1:0] REG_LEVEL = 4'hC;
  localparam int CTRL_DEPTH_BIT = 0;     // Depth expansion mode
  localparam int LVL_FLAG_LSB = 16;      // Live flags in level register
  localparam int LVL_FLAG_W = 5;

  // Sticky event bits of status and mask
  localparam int ST_W = 7;
  localparam int ST_EMPTY = 0;
  localparam int ST_FULL = 1;
  localparam int ST_NEAR_E = 2;
  localparam int ST_NEAR_F = 3;
  localparam int ST_HALF = 4;
  localparam int ST_OVER = 5;
  localparam int ST_UNDER = 6;

  // Which offset register the next load access reaches
  typedef enum logic {
    SEL_EMPTY,
    SEL_FULL
  } sfx_sel_e;

endpackage
`default_nettype wire

// >>> sfx_sync.sv
// Three-flop pin synchroniser with second/third stage agreement
`default_nettype none
module sfx_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Raw pins in, filtered levels out
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  // Whole state of the synchroniser
  typedef struct packed {
    logic [W-1:0] s1;    // Metastable stage, read by s2 only
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] val;   // Accepted level
  } sfx_sync_s;

  sfx_sync_s r_reg;
  sfx_sync_s r_next;

  ////////////////////////////////////////////////////////////////////////////
  // Shift and accept a bit once two stages agree; delay is uniform per bit
  always_comb begin
    r_next = r_reg;
    r_next.s1 = async_i;
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    for (int i = 0; i < W; i++) begin
      if (r_reg.s2[i] == r_reg.s3[i]) begin
        r_next.val[i] = r_reg.s2[i];
      end
    end
  end

  // State register
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      r_reg <= {4{RESET_VAL}};
    end else begin
      r_reg <= r_next;
    end
  end

  assign sync_o = r_reg.val;

endmodule
`default_nettype wire

// >>> sfx_mem.sv
// Word store of one FIFO bank, one write port and one read port
`default_nettype none
module sfx_mem import sfx_pkg::*; (
  // Clock
  input wire logic core_clk_i,
  // Write port
  input wire logic wr_en_i,
  input wire logic [PTR_W-1:0] wr_addr_i,
  input wire logic [DATA_W-1:0] wr_data_i,
  // Read port, combinational
  input wire logic [PTR_W-1:0] rd_addr_i,
  output logic [DATA_W-1:0] rd_data_o
);

  // Storage; no reset, contents are undefined until written
  logic [DATA_W-1:0] mem [DEPTH];

  // Write on enable
  always_ff @(posedge core_clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  // Read is asynchronous so the bank can register it with its own flags
  assign rd_data_o = mem[rd_addr_i];

endmodule
`default_nettype wire

// >>> sfx_pin_ctl.sv
// Pin-side controller model: shared free-running write/read pin clock
`default_nettype none
module sfx_pin_ctl (
  // Core clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Pin clock and enable-change slot
  output logic pin_clk_o,
  output logic slot_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] ph_reg; // Phase within a ten-cycle pin period
  // Five high, five low: both halves outlast the pin sampler
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) ph_reg <= 4'h0;
    else ph_reg <= (ph_reg == 4'h9) ? 4'h0 : ph_reg + 4'h1;
  end
  assign pin_clk_o = ph_reg < 4'h5;
  // Enables move here, clear of the rising edge on both sides
  assign slot_o = ph_reg == 4'h7;
endmodule
`default_nettype wire

// >>> sfx_bank_bench.sv
// Self-checking bench for one flagged FIFO bank
`default_nettype none
module sfx_bank_bench;
  import sfx_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, rstn = 1, ld_n = 1, wen_n = 1, ren_n = 1;
  logic oe_n = 0, av_rd = 0, av_wr = 0, pclk, slot, dq_oe, ef, ff;
  logic near_empty_n, near_full_n, wr_chain_out_n, rd_chain_out_n, irq, wait_r;
  logic chead_n = 0, wci_n = 0, rci_n = 0; // Chain pins, grounded alone
  logic [DATA_W-1:0] din = '0, dq, last;
  logic [3:0] av_a = '0, av_be = '0;
  logic [31:0] av_d = '0, rdq, rq;
  int err_count = 0, n_compared = 0, cyc = 0, wlow, rlow, cnt, eo, fo;
  logic [DATA_W-1:0] fq[$]; // Words expected out, in order
  sfx_pin_ctl ctl_u (.core_clk_i(clk), .rst_i(rst), .pin_clk_o(pclk),
    .slot_o(slot));
  sfx_bank dut_u (.core_clk_i(clk), .rst_i(rst), .wr_clk_i(pclk),
    .wr_en_n_i(wen_n), .data_i(din), .rd_clk_i(pclk), .rd_en_n_i(ren_n),
    .out_en_n_i(oe_n), .data_o(dq), .data_oe_o(dq_oe), .rst_n_i(rstn),
    .offset_access_n_i(ld_n), .chain_head_n_i(chead_n),
    .wr_chain_in_n_i(wci_n), .rd_chain_in_n_i(rci_n), .empty_n_o(ef),
    .full_n_o(ff), .near_empty_n_o(near_empty_n), .near_full_n_o(near_full_n),
    .wr_chain_out_n_o(wr_chain_out_n), .rd_chain_out_n_o(rd_chain_out_n), .avs_address_i(av_a),
    .avs_read_i(av_rd), .avs_write_i(av_wr), .avs_writedata_i(av_d),
    .avs_byteenable_i(av_be), .avs_readdata_o(rdq),
    .avs_waitrequest_o(wait_r), .irq_o(irq));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic conclude();
    if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    n_compared++;
    if (!ok) begin
      err_count++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  // Cycle ceiling, and low-cycle counts of both chain outputs
  always @(posedge clk) begin
    cyc++;
    if (cyc > 60000) begin
      chk(1'b0, "timeout");
      conclude();
    end
    if (!wr_chain_out_n) wlow++;
    if (!rd_chain_out_n) rlow++;
  end
  // One bus access; waits for waitrequest low, the cycle ceiling ends a hang
  task automatic av(input logic w, input logic [3:0] a,
                    input logic [31:0] d, input logic [3:0] be);
    av_a <= a;
    av_wr <= w;
    av_rd <= !w;
    av_d <= d;
    av_be <= be;
    @(posedge clk);
    while (wait_r !== 1'b0) begin
      @(posedge clk);
    end
    rq = rdq;
    av_rd <= 1'b0;
    av_wr <= 1'b0;
    @(posedge clk);
  endtask
  // One pin clock period from a slot to the next
  task automatic step(input logic w, input logic r, input logic [17:0] d);
    wen_n <= !w;
    ren_n <= !r;
    din <= d;
    oe_n <= ($urandom % 4 == 0);
    @(posedge clk iff slot);
  endtask
  task automatic flags(input logic dm);
    chk(ef === (cnt != 0) && ff === (cnt != 1024), "empty/full");
    chk(near_empty_n === (cnt > eo) && near_full_n === (1024 - cnt > fo), "near");
    if (!dm) chk(wr_chain_out_n === (cnt <= 512), "half");
    chk(dq_oe === !oe_n, "drive");
  endtask
  task automatic prst();
    rstn <= 1'b0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (8) @(posedge clk);
    cnt = 0;
    eo = 127;
    fo = 127;
    @(posedge clk iff slot);
  endtask
  // Fill to full, then drain to empty, with refusals in single use
  task automatic run(input logic dm);
    wlow = 0;
    rlow = 0;
    for (int k = 0; k < 1024; k++) begin
      step(1'b1, 1'b0, DATA_W'($urandom));
      fq.push_back(din);
      cnt++;
      flags(dm);
    end
    if (!dm) begin
      step(1'b1, 1'b0, DATA_W'($urandom));
      flags(dm);
      chk(irq === 1'b1, "irq set");
      wen_n <= 1'b1;
      // Count 1024 in the low bits; only near-empty and empty flags high
      av(1'b0, REG_LEVEL, 32'h0, 4'hF);
      chk(rq === 32'h00050400, "level");
      av(1'b0, REG_STATUS, 32'h0, 4'hF);
      chk(rq[ST_OVER] === 1'b1 && rq[ST_FULL] === 1'b1, "status");
      repeat (3) @(posedge clk);
      chk(irq === 1'b0, "irq clear");
      @(posedge clk iff slot);
    end
    for (int k = 0; k < 1024; k++) begin
      step(1'b0, 1'b1, '0);
      last = fq.pop_front();
      chk(dq === last, "read word");
      cnt--;
      flags(dm);
    end
    if (!dm) begin
      step(1'b0, 1'b1, '0);
      chk(dq === last, "refused read");
      av(1'b0, REG_STATUS, 32'h0, 4'hF);
      chk(rq[ST_UNDER] === 1'b1, "under");
      chk(rlow === 0, "no read pulse");
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h842f));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    prst();
    chk(ef === 0 && near_empty_n === 0 && ff === 1 && near_full_n === 1, "reset");
    av(1'b1, REG_MASK, 32'h20, 4'hF);
    av(1'b1, REG_MASK, 32'h7F, 4'h0);
    av(1'b0, REG_MASK, 32'h0, 4'hF);
    chk(rq === 32'h20, "mask");
    av(1'b0, 4'h2, 32'h0, 4'hF);
    chk(rq === 32'h0, "unmapped");
    // Offsets: load both, then read both back in the same order
    @(posedge clk iff slot);
    eo = $urandom_range(200, 1);
    fo = $urandom_range(200, 1);
    ld_n <= 1'b0;
    step(1'b1, 1'b0, DATA_W'(eo));
    step(1'b1, 1'b0, DATA_W'(fo));
    step(1'b0, 1'b1, '0);
    chk(dq === DATA_W'(eo), "empty offset");
    step(1'b0, 1'b1, '0);
    chk(dq === DATA_W'(fo), "full offset");
    ld_n <= 1'b1;
    run(1'b0);
    // Depth mode as head device: chain pulses of two cycles
    av(1'b1, REG_CTRL, 32'h1, 4'hF);
    av(1'b0, REG_CTRL, 32'h0, 4'hF);
    chk(rq === 32'h1, "depth mode bit");
    prst();
    run(1'b1);
    chk(wlow === 2 && rlow === 2, "chain pulses");
    // Later device: no token after pin reset until the chain inputs fall
    chead_n <= 1'b1;
    wci_n <= 1'b1;
    rci_n <= 1'b1;
    prst();
    step(1'b1, 1'b0, DATA_W'($urandom));
    flags(1'b1);
    wci_n <= 1'b0;
    rci_n <= 1'b0;
    step(1'b1, 1'b0, DATA_W'($urandom));
    fq.push_back(din);
    cnt++;
    flags(1'b1);
    step(1'b0, 1'b1, '0);
    last = fq.pop_front();
    chk(dq === last, "chained read");
    cnt--;
    flags(1'b1);
    conclude();
  end
endmodule
`default_nettype wire
